// ---- ccl_local_regs.v ----
// Per-channel local configuration registers of a four-channel codec, behind the serial host control port
//
// Overview of operation
// - Command byte: address in bits 6..0, bit 7 clear reads, set writes.
// - Coefficient bit 7 enables receive digital gain from coefficient memory; default off.
// - Bits 6, 5, 4 enable rx correction, tx gain, tx correction; default off.
// - Coefficient bit 3 enables the high-pass stage; it resets enabled.
// - Bits 2, 1, 0 enable impedance gain, echo cancel, impedance match; default off.
// - Five enable bits 7..3 gate change interrupts of three bidir pins, two senses.
// - A bidir pin change interrupts only while it is an input and enabled.
// - Loopback bit 2 enables digital loopback through timeslots; default off.
// - Loopback bit 1 enables analog loopback through the one-bit stage; default off.
// - Loopback bit 0 enables digital loopback through the one-bit stage; default off.
// - Hook debounce time is low code times 2 ms, 0 to 30 ms; default 0.
// - Ground-key interval is high code times 2 ms; minimum time 0 to 180 ms.
// - Pin data register shows the seven signaling pins in bits 6..0; bit 7 reserved.
// - Writes to pin data never change bidir pins used as outputs.
// - Seven-bit transmit slot number 0 to 127; default 0.
// - Transmit slot bit 7 picks the second transmit highway; default first.
// - Seven-bit receive slot number 0 to 127; default 0.
// - Receive slot bit 7 picks the second receive highway; default first.
`timescale 1ns/1ns
`include "ccl_consts.vh"
module ccl_local_regs #(
  parameter CHANNELS = 4,
  parameter DEBOUNCE_STEP_CYCLES = `CCL_DEBOUNCE_STEP_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Host control port pins
  input wire hostSelN,
  input wire hostSclk,
  input wire hostSdi,
  output reg hostSdo,
  output reg hostSdoEn,
  // Channel chosen by the global channel selection
  input wire [1:0] chanSelect,
  // Signaling pins and their global configuration
  input wire [3*CHANNELS-1:0] bidirPinIn,
  input wire [3*CHANNELS-1:0] bidirPinIsOutput,
  input wire [3*CHANNELS-1:0] bidirPinOutValue,
  input wire [2*CHANNELS-1:0] signalOutputLevel,
  input wire [CHANNELS-1:0] hookSensePin,
  input wire [CHANNELS-1:0] groundKeySensePin,
  // Stage enables, eight per channel
  output wire [8*CHANNELS-1:0] coefStageEnable,
  // Loopback controls
  output wire [CHANNELS-1:0] digitalLoopTimeslot,
  output wire [CHANNELS-1:0] analogLoopOnebit,
  output wire [CHANNELS-1:0] digitalLoopOnebit,
  // Timeslot and highway selection
  output wire [7*CHANNELS-1:0] txSlotNumber,
  output wire [CHANNELS-1:0] txHighwaySelect,
  output wire [7*CHANNELS-1:0] rxSlotNumber,
  output wire [CHANNELS-1:0] rxHighwaySelect,
  // Filtered sense levels and change interrupt pulses
  output wire [CHANNELS-1:0] hookSenseLevel,
  output wire [CHANNELS-1:0] groundKeySenseLevel,
  output reg [CHANNELS-1:0] signalChangeIrq
);

  // Synchroniser vector, top down: select, serial clock, serial data,
  // then ground-key senses, hook senses and the bidir pins of all channels
  localparam PINW = 5 * CHANNELS + 3;

  // Register copies, one byte per channel each
  // Pin data has no storage: it is assembled from the pins at read time
  reg [8*CHANNELS-1:0] coefEnables_reg;
  reg [8*CHANNELS-1:0] loopIrq_reg;
  reg [8*CHANNELS-1:0] debounce_reg;
  reg [8*CHANNELS-1:0] txSlot_reg;
  reg [8*CHANNELS-1:0] rxSlot_reg;

  // Pin synchronisers and edge history
  reg [PINW-1:0] pinMeta_reg;
  reg [PINW-1:0] pinSync_reg;
  reg portHist_reg;

  // Serial port state and the change detector's last watched levels
  reg [3:0] bitCnt_reg;
  reg [7:0] cmd_reg;
  reg [7:0] wrShift_reg;
  reg [7:0] rdShift_reg;
  reg [5*CHANNELS-1:0] lastWatched_reg;

  // Decoded port events and per-channel views
  wire selN;
  wire sclk;
  wire sdi;
  wire sclkRise;
  wire sclkFall;
  wire [3*CHANNELS-1:0] bidirSync;
  wire [8*CHANNELS-1:0] pinDataByte;
  wire [5*CHANNELS-1:0] watched;
  wire writeDone;
  wire cmdDone;
  wire [7:0] writeByte;
  reg [7:0] readByte;

  assign selN = pinSync_reg[PINW-1];
  assign sclk = pinSync_reg[PINW-2];
  assign sdi = pinSync_reg[PINW-3];
  assign bidirSync = pinSync_reg[3*CHANNELS-1:0];

  // Every pin passes two flops before any logic looks at it
  // Port pins reset high, serial clock included; sense and bidir pins reset low like the
  // filtered levels and the change history, so reset itself never fakes an edge
  always @(posedge clk) begin
    if (!rst_n) begin
      pinMeta_reg <= {3'h7, {(5*CHANNELS){1'b0}}};
      pinSync_reg <= {3'h7, {(5*CHANNELS){1'b0}}};
    end else begin
      pinMeta_reg <= {hostSelN, hostSclk, hostSdi, groundKeySensePin, hookSensePin, bidirPinIn};
      pinSync_reg <= pinMeta_reg;
    end
  end

  // Edge history reads only the second sync stage
  // One previous serial clock level is enough; select needs no edge, only its level
  always @(posedge clk) begin
    if (!rst_n) begin
      portHist_reg <= 1'b1;
    end else begin
      portHist_reg <= sclk;
    end
  end

  // A pin edge reaches this detector three clocks late, so each serial clock level
  // must stand at least four clocks; a faster host loses bits with no error flag
  assign sclkRise = !selN && sclk && !portHist_reg;
  assign sclkFall = !selN && !sclk && portHist_reg;
  // Command completes on the 8th rising edge, data on the 16th
  // A second command may follow in the same select; the counter wraps after sixteen bits
  assign cmdDone = sclkRise && (bitCnt_reg == 4'h7);
  assign writeDone = sclkRise && (bitCnt_reg == 4'hf) && cmd_reg[`CCL_CMD_WRITE_BIT];
  // The data byte is taken whole at the 16th edge, its last bit straight from the line
  assign writeByte = {wrShift_reg[6:0], sdi};

  // Serial shifter: command then one data byte, MSB first, sampled on rising clock
  // Deselect clears the bit counter, so every new select starts with a command byte
  always @(posedge clk) begin
    if (!rst_n) begin
      bitCnt_reg <= 4'h0;
      cmd_reg <= 8'h00;
      wrShift_reg <= 8'h00;
    end else if (selN) begin
      bitCnt_reg <= 4'h0; // Deselect aborts any partial transfer
    end else if (sclkRise) begin
      if (bitCnt_reg < 4'h8) begin
        cmd_reg <= {cmd_reg[6:0], sdi};
      end else begin
        wrShift_reg <= writeByte;
      end
      if (bitCnt_reg != 4'hf) begin
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end else begin
        bitCnt_reg <= 4'h0; // Allows a second command in the same select
      end
    end
  end

  // Read data for the selected channel; unmapped offsets read as zero
  // chanSelect must stay steady through the command byte; it is not synchronised
  always @* begin
    readByte = 8'h00;
    // Until the eighth bit arrives, the command's direction bit sits one place lower
    if (cmd_reg[`CCL_CMD_WRITE_BIT - 1] == 1'b0) begin
      case ({cmd_reg[5:0], sdi})
        `CCL_OFS_COEF_ENABLES: readByte = coefEnables_reg[chanSelect*8 +: 8];
        `CCL_OFS_LOOP_IRQ: readByte = loopIrq_reg[chanSelect*8 +: 8];
        `CCL_OFS_DEBOUNCE: readByte = debounce_reg[chanSelect*8 +: 8];
        `CCL_OFS_PIN_DATA: readByte = pinDataByte[chanSelect*8 +: 8];
        `CCL_OFS_TX_SLOT: readByte = txSlot_reg[chanSelect*8 +: 8];
        `CCL_OFS_RX_SLOT: readByte = rxSlot_reg[chanSelect*8 +: 8];
        default: readByte = 8'h00;
      endcase
    end
  end

  // Read output: loaded at command end, shifted on falling clock so the host samples on rising
  // The first data bit shows before the host's ninth rising edge; a write keeps the line off
  always @(posedge clk) begin
    if (!rst_n) begin
      rdShift_reg <= 8'h00;
      hostSdo <= 1'b0;
      hostSdoEn <= 1'b0;
    end else if (selN) begin
      hostSdoEn <= 1'b0;
      hostSdo <= 1'b0;
    end else if (cmdDone) begin
      rdShift_reg <= readByte;
      hostSdo <= readByte[7];
      hostSdoEn <= !cmd_reg[6]; // Bit 7 of the command still sits in cmd_reg[6] until this edge shifts in the last bit
    end else if (sclkFall && bitCnt_reg > 4'h8) begin
      rdShift_reg <= {rdShift_reg[6:0], 1'b0};
      hostSdo <= rdShift_reg[6];
    end else if (bitCnt_reg == 4'h0) begin
      hostSdoEn <= 1'b0; // Data byte finished
    end
  end

  // Per-channel logic: register copy, outputs, two debounce filters, change detector
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gChan
      wire wrThis;
      wire [2:0] bidirShown;
      wire [2:0] bidirIsIn;
      wire [4:0] irqEn;

      // The copy written is the one chanSelect names at the 16th rising edge
      assign wrThis = writeDone && (chanSelect == ch);

      // Register writes land in the selected channel copy only
      // A write needs all sixteen bits; a frame cut short by deselect changes nothing
      always @(posedge clk) begin
        if (!rst_n) begin
          coefEnables_reg[ch*8 +: 8] <= `CCL_RST_COEF_ENABLES;
          loopIrq_reg[ch*8 +: 8] <= `CCL_RST_LOOP_IRQ;
          debounce_reg[ch*8 +: 8] <= `CCL_RST_DEBOUNCE;
          txSlot_reg[ch*8 +: 8] <= `CCL_RST_TX_SLOT;
          rxSlot_reg[ch*8 +: 8] <= `CCL_RST_RX_SLOT;
        end else if (wrThis) begin
          // Offsets beyond the table and the pin data view store nothing
          case (cmd_reg[6:0])
            `CCL_OFS_COEF_ENABLES: coefEnables_reg[ch*8 +: 8] <= writeByte;
            `CCL_OFS_LOOP_IRQ: loopIrq_reg[ch*8 +: 8] <= writeByte;
            `CCL_OFS_DEBOUNCE: debounce_reg[ch*8 +: 8] <= writeByte;
            `CCL_OFS_TX_SLOT: txSlot_reg[ch*8 +: 8] <= writeByte;
            `CCL_OFS_RX_SLOT: rxSlot_reg[ch*8 +: 8] <= writeByte;
            default: txSlot_reg[ch*8 +: 8] <= txSlot_reg[ch*8 +: 8]; // Pin data writes dropped
          endcase
        end
      end

      // Stage enables go straight to the filter datapath
      // Every output below is a plain register bit with no logic in between
      assign coefStageEnable[ch*8 +: 8] = coefEnables_reg[ch*8 +: 8];
      assign digitalLoopTimeslot[ch] = loopIrq_reg[ch*8 + `CCL_BIT_DIGITAL_LOOP_TIMESLOT];
      assign analogLoopOnebit[ch] = loopIrq_reg[ch*8 + `CCL_BIT_ANALOG_LOOP_ONEBIT];
      assign digitalLoopOnebit[ch] = loopIrq_reg[ch*8 + `CCL_BIT_DIGITAL_LOOP_ONEBIT];
      assign txSlotNumber[ch*7 +: 7] = txSlot_reg[ch*8 +: 7];
      assign txHighwaySelect[ch] = txSlot_reg[ch*8 + `CCL_BIT_HIGHWAY_SELECT];
      assign rxSlotNumber[ch*7 +: 7] = rxSlot_reg[ch*8 +: 7];
      assign rxHighwaySelect[ch] = rxSlot_reg[ch*8 + `CCL_BIT_HIGHWAY_SELECT];

      // Both filters tick at the same step length, each on its own timer; the ground key counts six ticks per code step,
      // which keeps its longest code inside a seven-bit counter
      // Hook sense: code times one step
      ccl_debounce #(
        .TICK_CYCLES(DEBOUNCE_STEP_CYCLES),
        .MULT(`CCL_HOOK_MULT)
      ) uHook (
        .clk(clk),
        .rst_n(rst_n),
        .rawIn(pinSync_reg[3*CHANNELS + ch]),
        .code(debounce_reg[ch*8 + `CCL_HOOK_CODE_LSB +: 4]),
        .stableOut(hookSenseLevel[ch])
      );

      // Ground key: the interval is code times one step, held six intervals
      ccl_debounce #(
        .TICK_CYCLES(DEBOUNCE_STEP_CYCLES),
        .MULT(`CCL_GROUND_KEY_MULT)
      ) uGroundKey (
        .clk(clk),
        .rst_n(rst_n),
        .rawIn(pinSync_reg[4*CHANNELS + ch]),
        .code(debounce_reg[ch*8 + `CCL_GROUND_KEY_CODE_LSB +: 4]),
        .stableOut(groundKeySenseLevel[ch])
      );

      // Bidir pins show the driven value when outputs, the pin when inputs
      // An output pin reads back its global output value, and nothing written here reaches it
      // Debounced levels feed both the pin data view and the change detector
      assign bidirIsIn = ~bidirPinIsOutput[ch*3 +: 3];
      assign bidirShown = (bidirIsIn & bidirSync[ch*3 +: 3]) | (~bidirIsIn & bidirPinOutValue[ch*3 +: 3]);
      assign pinDataByte[ch*8 +: 8] = {1'b0, signalOutputLevel[ch*2 +: 2], bidirShown,
                                       groundKeySenseLevel[ch], hookSenseLevel[ch]};

      // Watched levels ordered as the enable field: pin c, b, a, ground key, hook
      assign watched[ch*5 +: 5] = {bidirShown, groundKeySenseLevel[ch], hookSenseLevel[ch]};
      assign irqEn = loopIrq_reg[ch*8 + `CCL_IRQ_EN_LSB +: 5];

      // One-cycle pulse on an enabled change; output-mode bidir pins never count
      // A pin high at reset shows one change a few clocks later; enables are off then
      always @(posedge clk) begin
        if (!rst_n) begin
          lastWatched_reg[ch*5 +: 5] <= 5'h00;
          signalChangeIrq[ch] <= 1'b0;
        end else begin
          lastWatched_reg[ch*5 +: 5] <= watched[ch*5 +: 5];
          signalChangeIrq[ch] <= |((watched[ch*5 +: 5] ^ lastWatched_reg[ch*5 +: 5]) & irqEn
                                   & {bidirIsIn, 2'h3});
        end
      end
    end
  endgenerate

endmodule

// ---- ccl_consts.vh ----
// Offsets, field positions, reset values and timing counts of the channel local registers
`ifndef CCL_CONSTS_VH
`define CCL_CONSTS_VH

// Command byte layout
`define CCL_CMD_WRITE_BIT 7
`define CCL_CMD_READ_CODE 8'h00
`define CCL_CMD_WRITE_CODE 8'h80

// Register offsets (low seven bits of the command byte)
`define CCL_OFS_COEF_ENABLES 7'h00
`define CCL_OFS_LOOP_IRQ 7'h01
`define CCL_OFS_DEBOUNCE 7'h02
`define CCL_OFS_PIN_DATA 7'h03
`define CCL_OFS_TX_SLOT 7'h04
`define CCL_OFS_RX_SLOT 7'h05

// Coefficient-stage enable bits
`define CCL_BIT_RX_DIGITAL_GAIN 7
`define CCL_BIT_RX_FREQ_CORRECTION 6
`define CCL_BIT_TX_DIGITAL_GAIN 5
`define CCL_BIT_TX_FREQ_CORRECTION 4
`define CCL_BIT_HIGHPASS_STAGE 3
`define CCL_BIT_IMPEDANCE_SCALING_GAIN 2
`define CCL_BIT_ECHO_CANCEL_STAGE 1
`define CCL_BIT_IMPEDANCE_MATCH_STAGE 0

// Loopback and interrupt enable fields
`define CCL_IRQ_EN_MSB 7
`define CCL_IRQ_EN_LSB 3
`define CCL_BIT_DIGITAL_LOOP_TIMESLOT 2
`define CCL_BIT_ANALOG_LOOP_ONEBIT 1
`define CCL_BIT_DIGITAL_LOOP_ONEBIT 0

// Debounce code fields
`define CCL_HOOK_CODE_LSB 0
`define CCL_GROUND_KEY_CODE_LSB 4

// Slot register fields
`define CCL_BIT_HIGHWAY_SELECT 7

// Reset values
`define CCL_RST_COEF_ENABLES 8'h08
`define CCL_RST_LOOP_IRQ 8'h00
`define CCL_RST_DEBOUNCE 8'h00
`define CCL_RST_TX_SLOT 8'h00
`define CCL_RST_RX_SLOT 8'h00

// Timing: one debounce step in ms, clock rate in MHz
`define CCL_DEBOUNCE_STEP_MS 2
`define CCL_CLK_MHZ 250
`define CCL_DEBOUNCE_STEP_CYCLES (`CCL_DEBOUNCE_STEP_MS * `CCL_CLK_MHZ * 1000)
// Ground-key minimum debounce time is six intervals (180 ms over 30 ms)
`define CCL_GROUND_KEY_MULT 6
`define CCL_HOOK_MULT 1

`endif

// ---- ccl_debounce.v ----
// Debounce filter for one sense input, programmable in steps of a fixed tick
`timescale 1ns/1ns
module ccl_debounce #(
  parameter TICK_CYCLES = 500000,
  parameter MULT = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Synchronised input and code
  input wire rawIn,
  input wire [3:0] code,
  // Filtered level
  output reg stableOut
);

  // Cut to the counter widths on purpose; a step must not exceed 2^20 cycles
  localparam integer TICK_LAST_FULL = TICK_CYCLES - 1;
  localparam integer MULT_FULL = MULT;
  localparam [19:0] TICK_LAST = TICK_LAST_FULL[19:0];
  localparam [6:0] MULT_TICKS = MULT_FULL[6:0];

  reg [19:0] tickCnt_reg;
  reg [6:0] holdCnt_reg;
  wire tick;
  wire [6:0] targetTicks;

  assign tick = (tickCnt_reg == TICK_LAST);
  // Widest target is 15 codes times 6, fits seven bits
  assign targetTicks = {3'h0, code} * MULT_TICKS;

  // Free-running step timer; a change is timed to whole steps, so it may settle up to one step early
  always @(posedge clk) begin
    if (!rst_n) begin
      tickCnt_reg <= 20'h00000;
    end else if (tick) begin
      tickCnt_reg <= 20'h00000;
    end else begin
      tickCnt_reg <= tickCnt_reg + 20'h00001;
    end
  end

  // Accept a new level once it has held through the programmed number of step ticks
  always @(posedge clk) begin
    if (!rst_n) begin
      stableOut <= 1'b0;
      holdCnt_reg <= 7'h00;
    end else if (code == 4'h0) begin
      stableOut <= rawIn;
      holdCnt_reg <= 7'h00;
    end else if (rawIn == stableOut) begin
      holdCnt_reg <= 7'h00;
    end else if (holdCnt_reg >= targetTicks) begin
      stableOut <= rawIn;
      holdCnt_reg <= 7'h00;
    end else if (tick) begin
      holdCnt_reg <= holdCnt_reg + 7'h01;
    end
  end

endmodule

// ---- ccl_local_regs_monitor.sv ----
// Checker of register outputs, host read enable, sense levels and change pulses
`timescale 1ns/1ns
module ccl_monitor #(parameter CHANNELS = 4) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host port
  input wire logic hostSelN,
  input wire logic hostSdoEn,
  // Register outputs
  input wire logic [8*CHANNELS-1:0] coefStageEnable,
  input wire logic [7*CHANNELS-1:0] txSlotNumber,
  input wire logic [7*CHANNELS-1:0] rxSlotNumber,
  // Sense pins, levels and change pulses
  input wire logic [CHANNELS-1:0] hookSensePin,
  input wire logic [CHANNELS-1:0] groundKeySensePin,
  input wire logic [CHANNELS-1:0] hookSenseLevel,
  input wire logic [CHANNELS-1:0] groundKeySenseLevel,
  input wire logic [CHANNELS-1:0] signalChangeIrq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Defaults seen in the first cycle after reset; only the high-pass enable is set
  property p_rst_vals;
    $rose(rst_n) |-> coefStageEnable == {CHANNELS{8'h08}} && txSlotNumber == 0 && rxSlotNumber == 0;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("register not at default after reset");
  // Read enable is off once select has stood high five cycles, and once on stays enabled at least four cycles
  property p_sdo_idle;
    hostSelN [*5] |-> !hostSdoEn;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("read enable while deselected");
  property p_sdo_sel;
    $rose(hostSdoEn) |-> (!hostSelN && hostSdoEn) [*4];
  endproperty
  a_sdo_sel: assert property (p_sdo_sel) else $error("read enable too short");
  // Without a frame nothing may move the stored settings
  property p_coef_hold;
    hostSelN [*5] |-> $stable(coefStageEnable);
  endproperty
  a_coef_hold: assert property (p_coef_hold) else $error("stage enables moved without a write");
  property p_slot_hold;
    hostSelN [*5] |-> $stable({txSlotNumber, rxSlotNumber});
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("slot select moved without a write");
  // A filtered level only ever moves towards the level on its pin
  property p_hook;
    $changed(hookSenseLevel[0]) |-> hookSenseLevel[0] == $past(hookSensePin[0], 2);
  endproperty
  a_hook: assert property (p_hook) else $error("hook level differs from pin");
  property p_gk;
    $changed(groundKeySenseLevel[0]) |-> groundKeySenseLevel[0] == $past(groundKeySensePin[0], 2);
  endproperty
  a_gk: assert property (p_gk) else $error("ground key level differs from pin");
  property p_irq;
    signalChangeIrq[0] |=> !signalChangeIrq[0];
  endproperty
  a_irq: assert property (p_irq) else $error("change pulse longer than one cycle");
  // Main scenarios reached
  c_read: cover property ($rose(hostSdoEn));
  c_irq: cover property (signalChangeIrq[0]);
  c_hook: cover property ($changed(hookSenseLevel[0]));
endmodule
bind ccl_local_regs ccl_monitor #(.CHANNELS(CHANNELS)) u_mon (.clk(clk), .rst_n(rst_n), .hostSelN(hostSelN),
  .hostSdoEn(hostSdoEn), .coefStageEnable(coefStageEnable), .txSlotNumber(txSlotNumber),
  .rxSlotNumber(rxSlotNumber), .hookSensePin(hookSensePin), .groundKeySensePin(groundKeySensePin),
  .hookSenseLevel(hookSenseLevel), .groundKeySenseLevel(groundKeySenseLevel), .signalChangeIrq(signalChangeIrq));

// ---- ccl_host_model.sv ----
// Host controller on the serial control port: one command and data frame per call
`timescale 1ns/1ns
module ccl_host_model #(parameter HALF = 6) (
  // Clock
  input wire logic clk,
  // Serial port
  output logic hostSelN,
  output logic hostSclk,
  output logic hostSdi,
  input wire logic hostSdo,
  input wire logic hostSdoEn,
  // Read result, one-cycle pulse
  output logic [7:0] rdData,
  output logic rdValid
);
  initial begin
    hostSelN = 1'b1;
    hostSclk = 1'b0;
    hostSdi = 1'b0;
    rdData = 8'h00;
    rdValid = 1'b0;
  end
  // Drive just after an edge so the port never samples a moving line
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Serial clock stands low between frames; each level is held well over four clocks
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd);
    logic [15:0] sh;
    logic [7:0] rd;
    sh = {cmd, wd};
    rd = 8'h00;
    waitc(1);
    hostSelN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      hostSdi = sh[i];
      waitc(HALF);
      if (i < 8) rd = {rd[6:0], hostSdoEn & hostSdo};
      hostSclk = 1'b1;
      waitc(HALF);
      hostSclk = 1'b0;
    end
    waitc(HALF);
    hostSelN = 1'b1;
    hostSdi = ~hostSdi; // Released line carries no stale bit
    if (!cmd[7]) begin
      rdData = rd;
      rdValid = 1'b1;
      waitc(1);
      rdValid = 1'b0;
    end
  endtask
endmodule

// ---- ccl_testbench.sv ----
// Self-checking bench: register traffic per channel, change pulses and sense debounce
`timescale 1ns/1ns
module testbench;
  localparam int STEP = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] chanSelect = 2'h0;
  logic [11:0] bidirPinIn = 12'h5a3;
  logic [11:0] bidirPinIsOutput = 12'h492;
  logic [11:0] bidirPinOutValue = 12'h36d;
  logic [7:0] signalOutputLevel = 8'hb4;
  logic [3:0] hookSensePin = 4'h5;
  logic [3:0] groundKeySensePin = 4'ha;
  wire hostSelN, hostSclk, hostSdi, hostSdo, hostSdoEn, rdValid;
  wire [7:0] rdData;
  wire [31:0] coefStageEnable;
  wire [27:0] txSlotNumber, rxSlotNumber;
  wire [3:0] digitalLoopTimeslot, analogLoopOnebit, digitalLoopOnebit, txHighwaySelect, rxHighwaySelect;
  wire [3:0] hookSenseLevel, groundKeySenseLevel, signalChangeIrq;
  logic [7:0] regs [4][6];
  logic [7:0] expq [$];
  logic [31:0] seed = 32'h7d1eb19a;
  int num_errors = 0;
  int cmp_count = 0;
  // Short debounce step keeps the run brief
  ccl_local_regs #(.CHANNELS(4), .DEBOUNCE_STEP_CYCLES(STEP)) dut (.clk(clk), .rst_n(rst_n),
    .hostSelN(hostSelN), .hostSclk(hostSclk), .hostSdi(hostSdi), .hostSdo(hostSdo), .hostSdoEn(hostSdoEn),
    .chanSelect(chanSelect), .bidirPinIn(bidirPinIn), .bidirPinIsOutput(bidirPinIsOutput),
    .bidirPinOutValue(bidirPinOutValue), .signalOutputLevel(signalOutputLevel), .hookSensePin(hookSensePin),
    .groundKeySensePin(groundKeySensePin), .coefStageEnable(coefStageEnable),
    .digitalLoopTimeslot(digitalLoopTimeslot), .analogLoopOnebit(analogLoopOnebit),
    .digitalLoopOnebit(digitalLoopOnebit), .txSlotNumber(txSlotNumber), .txHighwaySelect(txHighwaySelect),
    .rxSlotNumber(rxSlotNumber), .rxHighwaySelect(rxHighwaySelect), .hookSenseLevel(hookSenseLevel),
    .groundKeySenseLevel(groundKeySenseLevel), .signalChangeIrq(signalChangeIrq));
  ccl_host_model host (.clk(clk), .hostSelN(hostSelN), .hostSclk(hostSclk), .hostSdi(hostSdi),
    .hostSdo(hostSdo), .hostSdoEn(hostSdoEn), .rdData(rdData), .rdValid(rdValid));
  // 250 MHz clock
  always #2 clk = ~clk;
  function automatic logic [7:0] lfsr8();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  // Output pins read back the driven value, input pins their own level
  function automatic logic [7:0] pinByte(input int c);
    logic [2:0] bi;
    bi = (bidirPinIsOutput[3*c+:3] & bidirPinOutValue[3*c+:3]) | (~bidirPinIsOutput[3*c+:3] & bidirPinIn[3*c+:3]);
    return {1'b0, signalOutputLevel[2*c+:2], bi, groundKeySensePin[c], hookSensePin[c]};
  endfunction
  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Pin data and unmapped offsets keep nothing
  task automatic wr(input logic [1:0] ch, input logic [6:0] ofs, input logic [7:0] d);
    if (ofs == 7'h00) d[2] = d[0];
    chanSelect = ch;
    host.xfer({1'b1, ofs}, d);
    if (ofs < 7'h06 && ofs != 7'h03) regs[ch][ofs] = d;
  endtask
  task automatic rd(input logic [1:0] ch, input logic [6:0] ofs);
    chanSelect = ch;
    expq.push_back(ofs == 7'h03 ? pinByte(ch) : (ofs < 7'h06 ? regs[ch][ofs] : 8'h00));
    host.xfer({1'b0, ofs}, lfsr8());
  endtask
  task automatic chkOut();
    for (int c = 0; c < 4; c++) begin
      chk("coefStageEnable", regs[c][0], coefStageEnable[8*c+:8]);
      chk("loopbacks", regs[c][1][2:0], {digitalLoopTimeslot[c], analogLoopOnebit[c], digitalLoopOnebit[c]});
      chk("txSlot", regs[c][4], {txHighwaySelect[c], txSlotNumber[7*c+:7]});
      chk("rxSlot", regs[c][5], {rxHighwaySelect[c], rxSlotNumber[7*c+:7]});
    end
  endtask
  task automatic irqSeen(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(posedge clk);
      seen = seen | (signalChangeIrq[0] === 1'b1);
    end
    #1;
    chk("signalChangeIrq", exp, seen);
  endtask
  // Toggle a sense pin and time how long its filtered level takes to follow
  task automatic settle(input int sel, input int lo, input int hi);
    int n;
    n = 0;
    if (sel == 0) hookSensePin[0] = ~hookSensePin[0];
    else groundKeySensePin[0] = ~groundKeySensePin[0];
    while (n < 400 && (sel == 0 ? hookSenseLevel[0] !== hookSensePin[0] : groundKeySenseLevel[0] !== groundKeySensePin[0])) begin
      tick(1);
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      final_report();
    end else begin
      chk("debounceDelay", 1, n >= lo && n <= hi);
    end
  endtask
  // Each finished read is paired with the oldest noted expectation
  always @(posedge clk) begin
    if (rdValid === 1'b1) chk("readData", expq.pop_front(), rdData);
  end
  initial begin
    for (int c = 0; c < 4; c++) regs[c] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    tick(3);
    rst_n = 1'b1;
    tick(2);
    chkOut();
    for (int o = 0; o < 7; o++) rd(2'd0, o[6:0]);
    for (int c = 3; c >= 0; c--) begin
      for (int o = 0; o < 7; o++) wr(c[1:0], o[6:0], lfsr8());
    end
    for (int c = 0; c < 4; c++) begin
      for (int o = 0; o < 7; o++) rd(c[1:0], o[6:0]);
    end
    chkOut();
    // Enabled hook, disabled ground key, bidir pin as output then as input
    wr(2'd0, 7'h02, 8'h00);
    wr(2'd0, 7'h01, 8'h08);
    hookSensePin[0] = ~hookSensePin[0];
    irqSeen(1'b1);
    groundKeySensePin[0] = ~groundKeySensePin[0];
    irqSeen(1'b0);
    bidirPinIsOutput[0] = 1'b1;
    wr(2'd0, 7'h01, 8'h20);
    bidirPinIn[0] = ~bidirPinIn[0];
    irqSeen(1'b0);
    bidirPinIsOutput[0] = 1'b0;
    tick(20);
    bidirPinIn[0] = ~bidirPinIn[0];
    irqSeen(1'b1);
    // Hook code 3 and ground key code 1, the latter counted six times
    wr(2'd0, 7'h02, 8'h13);
    settle(0, 2 * STEP, 3 * STEP + 8);
    settle(1, 5 * STEP, 6 * STEP + 8);
    rd(2'd0, 7'h03);
    tick(2);
    final_report();
  end
endmodule
